// ### logic/fcsr_map.svh
// bit positions, reset values and write masks of the fpu control/status/tag bank
`ifndef FCSR_MAP_SVH
`define FCSR_MAP_SVH
`define FCSR_STAT_BUSY_COPY   15
`define FCSR_STAT_CC_HIGH     14
`define FCSR_STAT_TOP_MSB     13
`define FCSR_STAT_TOP_LSB     11
`define FCSR_STAT_CC_LOW_MSB  10
`define FCSR_STAT_CC_LOW_LSB  8
`define FCSR_STAT_ERR_SUM     7
`define FCSR_STAT_STK_FAULT   6
`define FCSR_EXC_MSB          5
`define FCSR_EXC_INVALID      0
`define FCSR_CTRL_RND_MSB     11
`define FCSR_CTRL_RND_LSB     10
`define FCSR_CTRL_PREC_MSB    9
`define FCSR_CTRL_PREC_LSB    8
`define FCSR_CTRL_WMASK       16'h0F3F
`define FCSR_CTRL_RESET       16'h037F
`define FCSR_STAT_RESET       16'h0000
`define FCSR_TAG_RESET        16'hFFFF
`define FCSR_CLASS_VALID      2'h0
`define FCSR_CLASS_ZERO       2'h1
`define FCSR_CLASS_SPECIAL    2'h2
`define FCSR_CLASS_EMPTY      2'h3
`endif

// ### logic/fcsr_pkg.sv
// types shared by the fpu control/status/tag bank
package fcsr_pkg;
    typedef enum logic [1:0] {
        ENV_SEL_CTRL,
        ENV_SEL_STATUS,
        ENV_SEL_TAG,
        ENV_SEL_NONE
    } fcsr_env_sel_t;

    typedef struct packed {
        logic          rd;
        logic          wr;
        fcsr_env_sel_t sel;
        logic [15:0]   wdata;
    } fcsr_env_req_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] idx;
        logic       empty;
        logic       zero;
        logic       denormal;
        logic       infinity;
        logic       qnan;
        logic       snan;
        logic       unsupported;
    } fcsr_class_upd_t;
endpackage

// ### logic/fcsr_regs.sv
// fpu tag word, status word and mode control word with environment save/restore port
`include "fcsr_map.svh"

// Notes on behaviour
// - eight 2-bit class fields, reg7 on top
// - hardware reclasses fields; encoding 2 is special
// - status bit 15 mirrors error summary
// - status bits 13:11 hold stack top
// - condition codes at 14 and 10:8
// - unmasked exception sets error summary
// - status bit 6 flags stack fault
// - bits 5:0 are sticky exception flags
// - control bits 5:0 mask exception traps
// - control bits 11:10 select rounding
// - control bits 9:8 select precision
// - control word changed only via environment restore; status and tags also by datapath events
module fcsr_regs
    import fcsr_pkg::*;
(
    // clock and reset
    input  wire logic            mclk_in,
    input  wire logic            resetn_in,
    // environment store/restore sequencer
    input  wire fcsr_env_req_t   env_req_in,
    output logic [15:0]          env_rdata_out,
    output logic                 env_rvalid_out,
    // datapath events
    input  wire fcsr_class_upd_t class_upd_in,
    input  wire logic            stk_push_in,
    input  wire logic            stk_pop_in,
    input  wire logic            cc_wr_in,
    input  wire logic [3:0]      cc_in,
    input  wire logic            exc_valid_in,
    input  wire logic [5:0]      exc_flags_in,
    // mode and trap outputs
    output logic [1:0]           rounding_select_out,
    output logic [1:0]           precision_select_out,
    output logic [2:0]           stack_top_out,
    output logic                 trap_req_out
);
    logic [15:0] tags_ff;
    logic [15:0] nxt_tags;
    logic [15:0] ctrl_ff;
    logic [15:0] nxt_ctrl;
    logic [2:0]  top_ff;
    logic [2:0]  nxt_top;
    logic [3:0]  cc_ff;
    logic [3:0]  nxt_cc;
    logic        err_sum_ff;
    logic        nxt_err_sum;
    logic        fault_ff;
    logic        nxt_fault;
    logic [5:0]  exc_ff;
    logic [5:0]  nxt_exc;
    logic [15:0] rdata_ff;
    logic        rvalid_ff;

    function automatic logic [1:0] classify(input fcsr_class_upd_t u);
        logic [1:0] c;
        c = `FCSR_CLASS_VALID;
        if (u.empty) begin
            c = `FCSR_CLASS_EMPTY;
        end else if (u.denormal | u.infinity | u.qnan | u.snan | u.unsupported) begin
            c = `FCSR_CLASS_SPECIAL;
        end else if (u.zero) begin
            c = `FCSR_CLASS_ZERO;
        end
        return c;
    endfunction

    function automatic logic [1:0] field(input logic [15:0] t, input logic [2:0] i);
        return t[{i, 1'b0} +: 2];
    endfunction

    // decode of the environment port
    wire         wr_ctrl   = env_req_in.wr && env_req_in.sel == ENV_SEL_CTRL;
    wire         wr_status = env_req_in.wr && env_req_in.sel == ENV_SEL_STATUS;
    wire         wr_tag    = env_req_in.wr && env_req_in.sel == ENV_SEL_TAG;
    wire [15:0]  wd        = env_req_in.wdata;

    // stack movement and fault detection
    wire [2:0]   push_top  = top_ff - 3'h1;
    wire [2:0]   pop_top   = top_ff + 3'h1;
    wire         push_ok   = stk_push_in && !stk_pop_in;
    wire         pop_ok    = stk_pop_in && !stk_push_in;
    wire         stk_fault = (push_ok && field(tags_ff, push_top) != `FCSR_CLASS_EMPTY)
                           || (pop_ok && field(tags_ff, top_ff) == `FCSR_CLASS_EMPTY);
    wire [5:0]   exc_evt   = (exc_valid_in ? exc_flags_in : 6'h00)
                           | {5'h00, stk_fault};
    wire         err_set   = |(exc_evt & ~ctrl_ff[`FCSR_EXC_MSB:`FCSR_EXC_INVALID]);

    wire [15:0]  status_word = {err_sum_ff, cc_ff[3], top_ff, cc_ff[2:0],
                                err_sum_ff, fault_ff, exc_ff};

    always_comb begin
        nxt_tags = wr_tag ? wd : tags_ff;
        if (class_upd_in.valid) begin
            nxt_tags[{class_upd_in.idx, 1'b0} +: 2] = classify(class_upd_in);
        end
    end

    // restore loads a field, flag events are or-ed on top so a set is never lost; tag, cc and top events override it
    // sticky exception flags
    assign nxt_exc  = (wr_status ? wd[`FCSR_EXC_MSB:`FCSR_EXC_INVALID] : exc_ff) | exc_evt;
    assign nxt_err_sum = (wr_status ? wd[`FCSR_STAT_ERR_SUM] : err_sum_ff) | err_set;
    assign nxt_fault   = (wr_status ? wd[`FCSR_STAT_STK_FAULT] : fault_ff) | stk_fault;
    assign nxt_cc   = cc_wr_in ? cc_in
                    : wr_status ? {wd[`FCSR_STAT_CC_HIGH],
                                   wd[`FCSR_STAT_CC_LOW_MSB:`FCSR_STAT_CC_LOW_LSB]}
                    : cc_ff;
    assign nxt_top  = push_ok ? push_top
                    : pop_ok ? pop_top
                    : wr_status ? wd[`FCSR_STAT_TOP_MSB:`FCSR_STAT_TOP_LSB]
                    : top_ff;
    assign nxt_ctrl = wr_ctrl ? (wd & `FCSR_CTRL_WMASK) : ctrl_ff;

    wire [15:0]  rd_mux = env_req_in.sel == ENV_SEL_CTRL   ? ctrl_ff
                        : env_req_in.sel == ENV_SEL_STATUS ? status_word
                        : env_req_in.sel == ENV_SEL_TAG    ? tags_ff
                        : 16'h0000;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tags_ff <= `FCSR_TAG_RESET;
            ctrl_ff <= `FCSR_CTRL_RESET;
            top_ff  <= 3'h0;
            cc_ff   <= 4'h0;
            err_sum_ff <= 1'b0;
            fault_ff   <= 1'b0;
            exc_ff  <= 6'h00;
        end else begin
            tags_ff <= nxt_tags;
            ctrl_ff <= nxt_ctrl;
            top_ff  <= nxt_top;
            cc_ff   <= nxt_cc;
            err_sum_ff <= nxt_err_sum;
            fault_ff   <= nxt_fault;
            exc_ff  <= nxt_exc;
        end
    end

    // store data is registered so the output comes from a flop
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= env_req_in.rd ? rd_mux : rdata_ff;
            rvalid_ff <= env_req_in.rd;
        end
    end

    assign env_rdata_out        = rdata_ff;
    assign env_rvalid_out       = rvalid_ff;
    assign rounding_select_out  = ctrl_ff[`FCSR_CTRL_RND_MSB:`FCSR_CTRL_RND_LSB];
    assign precision_select_out = ctrl_ff[`FCSR_CTRL_PREC_MSB:`FCSR_CTRL_PREC_LSB];
    assign stack_top_out        = top_ff;
    // trap request follows the error summary; delivery is outside this block
    assign trap_req_out         = err_sum_ff;

    // checks
    property p_tag_class;
        @(posedge mclk_in) disable iff (!resetn_in)
        class_upd_in.valid |=> field(tags_ff, $past(class_upd_in.idx))
                               == $past(classify(class_upd_in));
    endproperty
    a_tag_class: assert property (p_tag_class) else $error("tag not reclassed");

    property p_special;
        @(posedge mclk_in) disable iff (!resetn_in)
        class_upd_in.valid && !class_upd_in.empty && class_upd_in.qnan
            |=> field(tags_ff, $past(class_upd_in.idx)) == `FCSR_CLASS_SPECIAL;
    endproperty
    a_special: assert property (p_special) else $error("nan not tagged special");

    property p_busy_copy;
        @(posedge mclk_in) disable iff (!resetn_in)
        env_req_in.rd && env_req_in.sel == ENV_SEL_STATUS
            |=> env_rdata_out[`FCSR_STAT_BUSY_COPY] == $past(trap_req_out)
                && env_rdata_out[`FCSR_STAT_ERR_SUM] == $past(trap_req_out);
    endproperty
    a_busy_copy: assert property (p_busy_copy) else $error("bit 15 differs from bit 7");

    property p_top_push;
        @(posedge mclk_in) disable iff (!resetn_in)
        stk_push_in && !stk_pop_in |=> stack_top_out == $past(stack_top_out) - 3'h1;
    endproperty
    a_top_push: assert property (p_top_push) else $error("push did not lower top");

    sequence s_cc_then_store;
        cc_wr_in ##1 (env_req_in.rd && env_req_in.sel == ENV_SEL_STATUS && !cc_wr_in);
    endsequence
    property p_cc_read;
        @(posedge mclk_in) disable iff (!resetn_in)
        s_cc_then_store |=> {env_rdata_out[14], env_rdata_out[10:8]} == $past(cc_in, 2);
    endproperty
    a_cc_read: assert property (p_cc_read) else $error("condition codes misplaced");

    sequence s_unmasked;
        exc_valid_in && |(exc_flags_in & ~ctrl_ff[5:0]);
    endsequence
    property p_err_sum;
        @(posedge mclk_in) disable iff (!resetn_in)
        s_unmasked |=> trap_req_out;
    endproperty
    a_err_sum: assert property (p_err_sum) else $error("unmasked exception missed");

    property p_stk_fault;
        @(posedge mclk_in) disable iff (!resetn_in)
        stk_pop_in && !stk_push_in && field(tags_ff, top_ff) == `FCSR_CLASS_EMPTY
            |=> fault_ff && exc_ff[`FCSR_EXC_INVALID];
    endproperty
    a_stk_fault: assert property (p_stk_fault) else $error("empty pop not flagged");

    property p_sticky;
        @(posedge mclk_in) disable iff (!resetn_in)
        exc_valid_in |=> (exc_ff & $past(exc_flags_in)) == $past(exc_flags_in);
    endproperty
    a_sticky: assert property (p_sticky) else $error("exception flag lost");

    property p_masked;
        @(posedge mclk_in) disable iff (!resetn_in)
        !err_sum_ff && !wr_status && !stk_fault && exc_valid_in
            && (exc_flags_in & ~ctrl_ff[5:0]) == 6'h00 |=> !trap_req_out;
    endproperty
    a_masked: assert property (p_masked) else $error("masked exception trapped");

    property p_ctrl_restore;
        @(posedge mclk_in) disable iff (!resetn_in)
        wr_ctrl |=> rounding_select_out == $past(wd[11:10])
                    && precision_select_out == $past(wd[9:8]);
    endproperty
    a_ctrl_restore: assert property (p_ctrl_restore) else $error("mode not restored");

    property p_store;
        @(posedge mclk_in) disable iff (!resetn_in)
        env_req_in.rd && env_req_in.sel == ENV_SEL_CTRL |=> env_rvalid_out
            && env_rdata_out == $past(ctrl_ff);
    endproperty
    a_store: assert property (p_store) else $error("control store wrong");
endmodule

// ### tb/fcsr_seq_model.sv
// environment store/restore sequencer model on the far side of the bank
module fcsr_seq_model
    import fcsr_pkg::*;
(
    // commands from the bench
    input  wire logic          rd_in,
    input  wire logic          wr_in,
    input  wire fcsr_env_sel_t sel_in,
    input  wire logic [15:0]   wdata_in,
    // request towards the bank
    output fcsr_env_req_t      env_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // reserved control bits restored as zero
    wire logic [15:0] clean_wdata;
    assign clean_wdata = (sel_in == ENV_SEL_CTRL) ? (wdata_in & 16'h0F3F) : wdata_in;
    // control word reached only by store/restore requests; status and tag words also change on datapath events
    // idle data is inverted so a stale word is never taken by mistake
    assign env_req_out = '{rd_in, wr_in, sel_in, wr_in ? clean_wdata : ~wdata_in};
endmodule

// ### tb/fcsr_regs_tb.sv
// self-checking bench for the fpu control/status/tag bank
module fcsr_regs_tb import fcsr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic            mclk_in = 1'b0;
    logic            resetn_in = 1'b0;
    logic            rd = 1'b0;
    logic            wr = 1'b0;
    fcsr_env_sel_t   sel = ENV_SEL_NONE;
    logic [15:0]     wdata = 16'h0000;
    fcsr_env_req_t   env_req;
    fcsr_class_upd_t class_upd = '0;
    logic            push = 1'b0;
    logic            pop = 1'b0;
    logic            cc_wr = 1'b0;
    logic            exc_valid = 1'b0;
    logic [3:0]      cc = 4'h0;
    logic [5:0]      exc_flags = 6'h00;
    logic [15:0]     rdata;
    logic [15:0]     exp_tag;
    logic [15:0]     wd;
    logic            rvalid;
    logic            trap;
    logic [1:0]      rnd;
    logic [1:0]      prec;
    logic [2:0]      top;
    logic [15:0]     exp_q[$];
    int              errors = 0;
    int              comparisons = 0;

    fcsr_seq_model seq (.rd_in(rd), .wr_in(wr), .sel_in(sel), .wdata_in(wdata),
        .env_req_out(env_req));
    fcsr_regs dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .env_req_in(env_req),
        .env_rdata_out(rdata), .env_rvalid_out(rvalid), .class_upd_in(class_upd),
        .stk_push_in(push), .stk_pop_in(pop), .cc_wr_in(cc_wr), .cc_in(cc),
        .exc_valid_in(exc_valid), .exc_flags_in(exc_flags), .rounding_select_out(rnd),
        .precision_select_out(prec), .stack_top_out(top), .trap_req_out(trap));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic env_wr(input fcsr_env_sel_t s, input logic [15:0] d);
        @(negedge mclk_in);
        wr = 1'b1;
        sel = s;
        wdata = d;
        @(negedge mclk_in);
        wr = 1'b0;
    endtask
    task automatic env_rd(input fcsr_env_sel_t s, input logic [15:0] e);
        @(negedge mclk_in);
        rd = 1'b1;
        sel = s;
        exp_q.push_back(e);
        @(negedge mclk_in);
        rd = 1'b0;
    endtask
    // strobes are single pulses; the extra cycle lets the update land
    task automatic strobe_clear();
        @(negedge mclk_in);
        class_upd = '0;
        push = 1'b0;
        pop = 1'b0;
        cc_wr = 1'b0;
        exc_valid = 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // store answers are matched against the oldest expectation
    always @(negedge mclk_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() != 0) begin
                chk(rdata, exp_q.pop_front());
            end else begin
                errors++;
                $display("Error at %0t: got %h expected %h", $time, rdata, ~rdata);
            end
        end
    end

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    initial begin
        void'($urandom(36279));
        repeat (16) @(negedge mclk_in);
        resetn_in = 1'b1;
        env_rd(ENV_SEL_CTRL, 16'h037F);
        env_rd(ENV_SEL_STATUS, 16'h0000);
        env_rd(ENV_SEL_TAG, 16'hFFFF);
        env_wr(ENV_SEL_NONE, 16'h1234);
        env_rd(ENV_SEL_NONE, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wd = (16'($urandom()) & 16'hF0FF) | (16'(i) << 10) | (16'(i) << 8);
            env_wr(ENV_SEL_CTRL, wd);
            env_rd(ENV_SEL_CTRL, wd & 16'h0F3F);
            chk({14'h0, rnd}, 16'(i));
            chk({14'h0, prec}, 16'(i));
        end
        $display("test mode control done");
        env_wr(ENV_SEL_CTRL, 16'h033E);
        exp_tag = 16'hFFFF;
        for (int k = 0; k < 8; k++) begin
            @(negedge mclk_in);
            class_upd = {1'b1, 3'(k), 7'(7'h40 >> k)};
            exp_tag[2*k +: 2] = (k == 0) ? 2'h3 : (k == 1) ? 2'h1 : (k == 7) ? 2'h0 : 2'h2;
            strobe_clear();
        end
        env_rd(ENV_SEL_TAG, exp_tag);
        wd = 16'($urandom()) | 16'h0003;
        env_wr(ENV_SEL_TAG, wd);
        env_rd(ENV_SEL_TAG, wd);
        $display("test class tags done");
        @(negedge mclk_in);
        cc_wr = 1'b1;
        cc = 4'hA;
        exc_valid = 1'b1;
        exc_flags = 6'h20;
        // store right behind the update, so the new codes must already show
        @(negedge mclk_in);
        cc_wr = 1'b0;
        exc_valid = 1'b0;
        rd = 1'b1;
        sel = ENV_SEL_STATUS;
        exp_q.push_back(16'h4220);
        @(negedge mclk_in);
        rd = 1'b0;
        chk({15'h0, trap}, 16'h0000);
        @(negedge mclk_in);
        exc_valid = 1'b1;
        exc_flags = 6'h01;
        strobe_clear();
        env_rd(ENV_SEL_STATUS, 16'hC2A1);
        chk({15'h0, trap}, 16'h0001);
        env_wr(ENV_SEL_STATUS, 16'h8000);
        env_rd(ENV_SEL_STATUS, 16'h0000);
        $display("test status flags done");
        @(negedge mclk_in);
        pop = 1'b1;
        strobe_clear();
        env_rd(ENV_SEL_STATUS, 16'h88C1);
        chk({13'h0, top}, 16'h0001);
        @(negedge mclk_in);
        push = 1'b1;
        strobe_clear();
        env_rd(ENV_SEL_STATUS, 16'h80C1);
        $display("test stack done");
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge mclk_in);
        if (exp_q.size() != 0) begin
            errors++;
        end
        complete_run();
    end
endmodule
